// [hw/supervisor_pkg.sv]
package supervisor_pkg;
  localparam logic [9:0] BASE_0 = 10'h190;
  localparam logic [9:0] BASE_1 = 10'h290;
  localparam logic [9:0] BASE_2 = 10'h390;
  localparam int WDOG_EN_BIT = 0;
  localparam int WDOG_KICK_BIT = 1;
  localparam int VPP_EN_BIT = 2;
  localparam int DIR485_BIT = 3;
  localparam int STATUS_BIT = 3;
  localparam int STORED_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SUGGESTED_DEFAULT = 8'h42;

  typedef struct packed {
    logic dir485_en;
    logic vpp_en;
    logic wdog_en;
  } ctrl_out_s;
endpackage

// [hw/kick_detect.sv]
`timescale 1ns/1ps
// Watches the retrigger bit for a one, zero, one sequence of writes.
module kick_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic bit_val,
  output logic kick
);
  typedef enum logic [1:0] {IDLE, SAW_ONE, SAW_ZERO} kick_e;
  kick_e st_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= IDLE;
      kick <= 1'b0;
    end else begin
      kick <= 1'b0;
      if (wr) begin
        case (st_q)
          IDLE: st_q <= bit_val ? SAW_ONE : IDLE;
          SAW_ONE: st_q <= bit_val ? SAW_ONE : SAW_ZERO;
          SAW_ZERO: begin
            if (bit_val) begin
              kick <= 1'b1;
              st_q <= SAW_ONE;
            end else begin
              st_q <= IDLE;
            end
          end
          default: st_q <= IDLE;
        endcase
      end
    end
  end
endmodule

// [hw/supervisor_reg.sv]
`timescale 1ns/1ps
// Host I/O slave for the supervisor control/status register.
module supervisor_reg (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  input wire logic [1:0] io_base_select_jumper,
  input wire logic [3:0] option_jumper_pairs,
  input wire logic power_status,
  input wire logic rs485_mode,
  output logic wdog_en,
  output logic wdog_kick,
  output logic vpp_en,
  output logic dir485_en
);
  logic [9:0] base;
  logic sel;
  logic [7:0] ctrl_q;
  logic [1:0] base_s1_q, base_s2_q;
  logic [3:0] opt_s1_q, opt_s2_q;
  logic pwr_s1_q, pwr_s2_q;
  logic mode_s1_q, mode_s2_q;
  logic wr;
  logic [7:0] ctrl_d;
  logic [3:0] opt_rd;
  logic [7:0] rd_word;
  supervisor_pkg::ctrl_out_s outs_q;

  // Jumpers and status pins are asynchronous; two flops before any use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_s1_q <= 2'h0;
      base_s2_q <= 2'h0;
      opt_s1_q <= 4'h0;
      opt_s2_q <= 4'h0;
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      base_s1_q <= io_base_select_jumper;
      base_s2_q <= base_s1_q;
      opt_s1_q <= option_jumper_pairs;
      opt_s2_q <= opt_s1_q;
      pwr_s1_q <= power_status;
      pwr_s2_q <= pwr_s1_q;
      mode_s1_q <= rs485_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  always_comb begin
    case (base_s2_q)
      2'h1: base = supervisor_pkg::BASE_1;
      2'h2: base = supervisor_pkg::BASE_2;
      default: base = supervisor_pkg::BASE_0;
    endcase
  end

  assign sel = (io_addr == base);
  assign io_hit = sel & (io_wr | io_rd);
  assign wr = sel & io_wr;

  // Bits 4 to 7 are kept although only status is read there
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr) begin
      ctrl_d = io_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= supervisor_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Jumper pair order is reversed on the bus: pair 0 shows on bit 7
  for (genvar g = 0; g < 4; g++) begin : g_opt
    assign opt_rd[3 - g] = opt_s2_q[g];
  end

  // Bit 3 reads status, never the stored direction bit
  always_comb begin
    rd_word = ctrl_q;
    rd_word[supervisor_pkg::STATUS_BIT] = pwr_s2_q;
    rd_word[7:4] = opt_rd;
  end

  // Read data registered; it stands one cycle and is zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (sel & io_rd) begin
      io_rdata <= rd_word;
    end else begin
      io_rdata <= 8'h00;
    end
  end

  // Outputs come from flops loaded with the next value, so they
  // change on the write edge and cannot glitch when the mode moves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outs_q <= '0;
    end else begin
      outs_q.wdog_en <= ctrl_d[supervisor_pkg::WDOG_EN_BIT];
      outs_q.vpp_en <= ctrl_d[supervisor_pkg::VPP_EN_BIT];
      outs_q.dir485_en <= ctrl_d[supervisor_pkg::DIR485_BIT]
                          & mode_s2_q;
    end
  end

  kick_detect u_kick (
    .clk(clk),
    .rst_b(rst_b),
    .wr(wr),
    .bit_val(io_wdata[supervisor_pkg::WDOG_KICK_BIT]),
    .kick(wdog_kick)
  );

  // Ports only ever see the registered copies
  assign wdog_en = outs_q.wdog_en;
  assign vpp_en = outs_q.vpp_en;
  assign dir485_en = outs_q.dir485_en;

  // Storage and reset
  reset_clear_a: assert property (@(posedge clk)
    $rose(rst_b) |-> ctrl_q == 8'h00)
    else $error("register not clear after reset");

  reset_outputs_a: assert property (@(posedge clk)
    $rose(rst_b) |-> !wdog_en && !vpp_en && !dir485_en && !wdog_kick)
    else $error("outputs not clear after reset");

  write_store_a: assert property (@(posedge clk)
    disable iff (!rst_b) wr |=> ctrl_q == $past(io_wdata))
    else $error("write not stored");

  store_hold_a: assert property (@(posedge clk)
    disable iff (!rst_b) !wr |=> $stable(ctrl_q))
    else $error("register changed without a write");

  // Read side
  read_status_a: assert property (@(posedge clk)
    disable iff (!rst_b) (sel && io_rd) |=> io_rdata[3] == $past(pwr_s2_q))
    else $error("bit 3 read not status");

  read_back_a: assert property (@(posedge clk)
    disable iff (!rst_b) (sel && io_rd && !wr) |=> io_rdata[2:0] == ctrl_q[2:0])
    else $error("bits 0-2 not read back");

  read_jumper_a: assert property (@(posedge clk)
    disable iff (!rst_b) (sel && io_rd) |=> io_rdata[7:4] == $past(opt_rd))
    else $error("jumper status not read");

  rdata_idle_a: assert property (@(posedge clk)
    disable iff (!rst_b) !(sel && io_rd) |=> io_rdata == 8'h00)
    else $error("read data not zero when idle");

  // Control outputs
  wdog_write_a: assert property (@(posedge clk)
    disable iff (!rst_b) wr |=> wdog_en == $past(io_wdata[0]))
    else $error("watchdog enable not loaded on write");

  vpp_write_a: assert property (@(posedge clk)
    disable iff (!rst_b) wr |=> vpp_en == $past(io_wdata[2]))
    else $error("programming voltage enable not loaded on write");

  dir_write_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    wr |=> dir485_en == ($past(io_wdata[3]) && $past(mode_s2_q)))
    else $error("direction control not loaded on write");

  dir_hold_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    !wr |=> dir485_en == (ctrl_q[3] && $past(mode_s2_q)))
    else $error("direction control lost between writes");

  dir_gate_a: assert property (@(posedge clk)
    disable iff (!rst_b) !mode_s2_q |=> !dir485_en)
    else $error("direction control outside RS-485 mode");

  // Decode per jumper setting
  decode_only_a: assert property (@(posedge clk)
    disable iff (!rst_b) (io_wr && io_addr != base) |=> $stable(ctrl_q))
    else $error("write at foreign address changed register");

  base_zero_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    (io_wr && base_s2_q == 2'h0 && io_addr == supervisor_pkg::BASE_0)
    |-> io_hit)
    else $error("write at first base not decoded");

  base_one_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    (io_wr && base_s2_q == 2'h1 && io_addr == supervisor_pkg::BASE_1)
    |-> io_hit)
    else $error("write at second base not decoded");

  base_two_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    (io_wr && base_s2_q == 2'h2 && io_addr == supervisor_pkg::BASE_2)
    |-> io_hit)
    else $error("write at third base not decoded");

  foreign_hit_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    ((io_wr || io_rd) && io_addr != base) |-> !io_hit)
    else $error("foreign address decoded");

  // Retrigger pulse
  kick_seq_a: assert property (@(posedge clk)
    disable iff (!rst_b) wdog_kick |-> $past(ctrl_q[1]) == 1'b0 && ctrl_q[1])
    else $error("kick without 0-1 transition");

  kick_width_a: assert property (@(posedge clk)
    disable iff (!rst_b) wdog_kick |=> !wdog_kick)
    else $error("kick pulse longer than one cycle");

  kick_write_a: assert property (@(posedge clk)
    disable iff (!rst_b) wdog_kick |-> $past(wr))
    else $error("kick without a write");
endmodule

// [verif/supervisor_reg_test.sv]
`timescale 1ns/1ps
module supervisor_reg_test;
  logic clk, rst_b, io_wr, io_rd, io_hit, power_status, rs485_mode, pend;
  logic wdog_en, wdog_kick, vpp_en, dir485_en, hit_exp;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, shadow, want;
  logic [1:0] io_base_select_jumper;
  logic [3:0] option_jumper_pairs;
  logic [9:0] bases [4];
  logic [7:0] exp_q [$];
  int n_errors, comparisons, seed, i, k;
  supervisor_reg u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .io_hit(io_hit),
    .io_base_select_jumper(io_base_select_jumper),
    .option_jumper_pairs(option_jumper_pairs),
    .power_status(power_status),
    .rs485_mode(rs485_mode),
    .wdog_en(wdog_en),
    .wdog_kick(wdog_kick),
    .vpp_en(vpp_en),
    .dir485_en(dir485_en)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic access(input logic [9:0] a, input logic wr,
                        input logic [7:0] d);
    logic [3:0] o;
    o = option_jumper_pairs;
    if (wr && a == bases[io_base_select_jumper]) shadow = d;
    if (!wr) exp_q.push_back(a != bases[io_base_select_jumper] ? 8'h00 :
      {o[0], o[1], o[2], o[3], power_status, shadow[2:0]});
    @(posedge clk);
    io_addr <= a;
    io_wr <= wr;
    io_rd <= !wr;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) pend <= io_rd;
  always @(negedge clk) begin
    hit_exp = (io_addr == bases[io_base_select_jumper]);
    if (io_wr || io_rd) check({7'h00, io_hit}, {7'h00, hit_exp});
    if (pend && exp_q.size() == 0) n_errors++;
    else if (pend) check(io_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    bases = '{10'h190, 10'h290, 10'h390, 10'h190};
    {rst_b, io_wr, io_rd, io_addr, io_wdata, shadow} = '0;
    {io_base_select_jumper, option_jumper_pairs, power_status} = 7'h35;
    rs485_mode = 1'b1;
    seed = 32'hCCB7F02F;
    repeat (16) @(posedge clk);
    check({4'h0, wdog_en, wdog_kick, vpp_en, dir485_en}, 8'h00);
    rst_b <= 1'b1;
    // Jumper and status pins need two edges through their synchronisers
    repeat (3) @(posedge clk);
    access(10'h190, 1'b0, 8'h00);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      io_base_select_jumper <= i[1:0];
      rs485_mode <= i[0];
      option_jumper_pairs <= 4'($random(seed));
      power_status <= 1'($random(seed));
      repeat (4) @(posedge clk);
      for (k = 0; k < 4; k++) begin
        access(bases[k], 1'b1, 8'($random(seed)));
        access(bases[k], 1'b0, 8'h00);
      end
      #1;
      want = {5'h0, shadow[3] & rs485_mode, shadow[2], shadow[0]};
      check({5'h0, dir485_en, vpp_en, wdog_en}, want);
      $display("test base select %0d done", i);
    end
    access(10'h190, 1'b1, 8'h02);
    access(10'h190, 1'b1, 8'h00);
    access(10'h190, 1'b1, 8'h02);
    // Pulse is registered on the third write edge and stands one cycle
    #1;
    check({7'h00, wdog_kick}, 8'h01);
    @(posedge clk);
    #1;
    check({7'h00, wdog_kick}, 8'h00);
    $display("test retrigger done");
    access(10'h190, 1'b1, supervisor_pkg::SUGGESTED_DEFAULT);
    access(10'h190, 1'b0, 8'h00);
    $display("test default pattern done");
    access(10'h190, 1'b1, 8'h0D);
    @(posedge clk);
    rst_b <= 1'b0;
    shadow = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, wdog_en, wdog_kick, vpp_en, dir485_en}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    access(10'h190, 1'b0, 8'h00);
    $display("test reset clear done");
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
